// *** rtl/pctr_map.svh ***
// Purpose: Constants for the PCI target responder: command codes, window layout,
//          configuration offsets, reset values, data enables and burst figures.
// Assumes: Included by its bare name from every file that needs it.
// Notes:   Definitions only.
`ifndef PCTR_MAP_SVH
`define PCTR_MAP_SVH

// Configuration space: latency-need register and the dword that holds it.
`define PCTR_LAT_NEED_OFS   8'h3F
`define PCTR_LAT_NEED_RST   8'h00
`define PCTR_LAT_NEED_DW    6'h0F
`define PCTR_LAT_NEED_LANE  24

// Command codes carried on the command/byte-enable lines in the address phase.
`define PCTR_CMD_CFG_RD     4'hA
`define PCTR_CMD_CFG_WR     4'hB
`define PCTR_CMD_IO_RD      4'h2
`define PCTR_CMD_IO_WR      4'h3
`define PCTR_CMD_MEM_RD     4'h6
`define PCTR_CMD_MEM_WR     4'h7

// Target window: 1M bytes, split in two halves of 512K bytes by address bit 19.
`define PCTR_WIN_BITS       20
`define PCTR_WIN_HALF_BIT   19
`define PCTR_BASE_BITS      12

// Data output enables and burst figures.
`define PCTR_ADEN_ON        4'hF
`define PCTR_ADEN_OFF       4'h0
`define PCTR_BURST_LAST     2'h3
`define PCTR_DW_STEP        20'h00004

`endif

// *** rtl/pctr_pkg.sv ***
// Purpose: Types shared by the PCI target responder.
// Assumes: Constants live in pctr_map.svh.
// Notes:   Nothing here is imported; users write pctr_pkg::name.
package pctr_pkg;

   // Target sequence states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DECODE,
      ST_CLAIM,
      ST_WAIT,
      ST_DATA,
      ST_TOFF,
      ST_BUSY
   } pctr_state_type;

endpackage : pctr_pkg

// *** rtl/pctr_wr_if.sv ***
// Purpose: Carrier for write words between the target sequencer and its buffer.
// Assumes: One clock domain.
// Notes:   A word moves on a cycle where valid and ready are both high.
`timescale 1ns/1ps
interface pctr_wr_if;
   logic        valid;
   logic        ready;
   logic [19:0] addr;
   logic [31:0] data;
   logic [3:0]  be;

   modport src (output valid, output addr, output data, output be, input ready);
   modport snk (input valid, input addr, input data, input be, output ready);
endinterface : pctr_wr_if

// *** rtl/pctr_buf.sv ***
// Purpose: Two-entry buffer between the bus write phases and the local write port.
// Assumes: Synchronous active-low reset; one clock.
// Notes:   Ready on the bus side is honest, so a stalled local side holds off
//          target-ready rather than losing a word.
`timescale 1ns/1ps
module pctr_buf (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   pctr_wr_if.snk           in_side,
   output      logic        out_valid,
   input  wire logic        out_ready,
   output      logic [19:0] out_addr,
   output      logic [31:0] out_data,
   output      logic [3:0]  out_be
);
   logic [55:0] mem_r [2];
   logic        wptr_r;
   logic        rptr_r;
   logic [1:0]  count_r;
   wire         push_w = in_side.valid && in_side.ready;
   wire         pop_w  = out_valid && out_ready;

   // Full and empty come straight from the occupancy count.
   assign in_side.ready = (count_r != 2'h2);
   assign out_valid     = (count_r != 2'h0);
   assign {out_addr, out_data, out_be} = mem_r[rptr_r];

   // Entries are written in place; only pointers and count are reset.
   always_ff @(posedge core_clk) begin
      if (push_w) begin
         mem_r[wptr_r] <= {in_side.addr, in_side.data, in_side.be};
      end
   end

   // Pointer and count update; a push and a pop together leave the count alone.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wptr_r  <= 1'b0;
         rptr_r  <= 1'b0;
         count_r <= 2'h0;
      end else begin
         wptr_r  <= wptr_r ^ push_w;
         rptr_r  <= rptr_r ^ pop_w;
         count_r <= count_r + {1'b0, push_w} - {1'b0, pop_w};
      end
   end
endmodule : pctr_buf

// *** rtl/pctr_top.sv ***
// Purpose: Target-side responder of a 32-bit PCI interface: claims configuration
//          and window accesses as a slow-decode target and sequences its enables.
// Assumes: All bus inputs are synchronous to core_clk; nrst is the bus reset.
// Notes:   Active-low bus signals keep the n in their names; enables are high
//          while this block drives the pins.
`timescale 1ns/1ps
`include "pctr_map.svh"
module pctr_top (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        framen_in,
   input  wire logic        irdyn_in,
   input  wire logic        idsel_in,
   input  wire logic [31:0] ad_in,
   input  wire logic [3:0]  cbe_in,
   input  wire logic [11:0] win_base,
   output      logic [31:0] ad_out,
   output      logic [3:0]  aden,
   output      logic        devseln_out,
   output      logic        trdyn_out,
   output      logic        stopn_out,
   output      logic        target_ctrl_out_enable,
   output      logic [7:0]  bus_latency_need,
   output      logic [7:0]  cfg_addr,
   input  wire logic [31:0] cfg_rd_data,
   output      logic        rd_req,
   output      logic        rd_local,
   output      logic [19:0] rd_addr,
   input  wire logic [31:0] dma_rd_data,
   input  wire logic        loc_rd_valid,
   input  wire logic [31:0] loc_rd_data,
   output      logic        wr_valid,
   input  wire logic        wr_ready,
   output      logic [19:0] wr_addr,
   output      logic [31:0] wr_data,
   output      logic [3:0]  wr_be
);
   pctr_pkg::pctr_state_type state_r, state_nxt;
   logic [19:0] addr_r;
   logic [3:0]  cmd_r;
   logic        hit_r, cfg_r, rd_r, loc_r, data_ok_r;
   logic [31:0] rdat_r;
   logic [1:0]  phase_r;

   pctr_wr_if wr_if ();

   // Command class decode, shared by the capture and by the checks below.
   function automatic logic is_cfg_cmd(input logic [3:0] c);
      is_cfg_cmd = (c == `PCTR_CMD_CFG_RD) || (c == `PCTR_CMD_CFG_WR);
   endfunction : is_cfg_cmd

   function automatic logic is_tgt_cmd(input logic [3:0] c);
      is_tgt_cmd = (c == `PCTR_CMD_IO_RD) || (c == `PCTR_CMD_IO_WR) ||
                   (c == `PCTR_CMD_MEM_RD) || (c == `PCTR_CMD_MEM_WR);
   endfunction : is_tgt_cmd

   // Address-phase decode of the live bus.
   // select qualifies config.
   wire cfg_hit_w = is_cfg_cmd(cbe_in) && idsel_in && (ad_in[1:0] == 2'h0);
   wire tgt_hit_w = is_tgt_cmd(cbe_in) &&
                    (ad_in[31:`PCTR_WIN_BITS] == win_base);
   wire addr_ph_w = (state_r == pctr_pkg::ST_IDLE) && !framen_in;

   // Phase qualifiers.
   wire in_claim_w = (state_r == pctr_pkg::ST_CLAIM) || (state_r == pctr_pkg::ST_WAIT) ||
                     (state_r == pctr_pkg::ST_DATA);
   wire in_data_w  = (state_r == pctr_pkg::ST_DATA);
   wire trdy_w     = in_data_w && (rd_r ? data_ok_r : (cfg_r || wr_if.ready));
   wire done_w     = trdy_w && !irdyn_in;
   wire stop_w     = trdy_w && (cfg_r || rd_r || (phase_r == `PCTR_BURST_LAST));
   wire last_w     = done_w && (stop_w || framen_in);

   // Bus-side outputs; control values are high whenever the control enable is low.
   // enables rise after turnaround.
   assign aden                   = (in_claim_w && rd_r) ? `PCTR_ADEN_ON : `PCTR_ADEN_OFF;
   assign target_ctrl_out_enable = in_claim_w || (state_r == pctr_pkg::ST_TOFF);
   assign devseln_out            = !in_claim_w;
   assign trdyn_out              = !trdy_w;
   assign stopn_out              = !stop_w;
   assign ad_out                 = rdat_r;
   assign bus_latency_need       = `PCTR_LAT_NEED_RST;
   assign cfg_addr               = {addr_r[7:2], 2'b00};

   // Local read request, shared by both halves of the window; only the local half waits for loc_rd_valid.
   // shared read request.
   assign rd_req   = (state_r == pctr_pkg::ST_CLAIM) && rd_r && !cfg_r;
   assign rd_local = loc_r;
   assign rd_addr  = addr_r;

   // Write words enter the buffer on each completed window write phase; config writes do not.
   assign wr_if.valid = done_w && !rd_r && !cfg_r;
   assign wr_if.addr  = addr_r;
   assign wr_if.data  = ad_in;
   assign wr_if.be    = cbe_in;

   // Sequencer next state.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         pctr_pkg::ST_IDLE: begin
            if (!framen_in) begin
               state_nxt = pctr_pkg::ST_DECODE;
            end
         end
         pctr_pkg::ST_DECODE: begin
            state_nxt = hit_r ? pctr_pkg::ST_CLAIM : pctr_pkg::ST_BUSY;
         end
         pctr_pkg::ST_CLAIM: begin
            state_nxt = pctr_pkg::ST_WAIT;
         end
         pctr_pkg::ST_WAIT: begin
            state_nxt = pctr_pkg::ST_DATA;
         end
         pctr_pkg::ST_DATA: begin
            if (last_w) begin
               state_nxt = pctr_pkg::ST_TOFF;
            end
         end
         pctr_pkg::ST_TOFF: begin
            state_nxt = pctr_pkg::ST_IDLE;
         end
         pctr_pkg::ST_BUSY: begin
            if (framen_in && irdyn_in) begin
               state_nxt = pctr_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = pctr_pkg::ST_IDLE;
         end
      endcase
   end

   // Config read word: the latency-need byte overrides its lane.
   wire [31:0] cfg_word_w = (addr_r[7:2] == `PCTR_LAT_NEED_DW) ?
                            {bus_latency_need, cfg_rd_data[23:0]} : cfg_rd_data;

   // State and address-phase capture.
   // capture on first frame edge.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_r <= pctr_pkg::ST_IDLE;
         addr_r  <= 20'h00000;
         cmd_r   <= 4'h0;
         hit_r   <= 1'b0;
         cfg_r   <= 1'b0;
         rd_r    <= 1'b0;
         loc_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (addr_ph_w) begin
            addr_r <= ad_in[`PCTR_WIN_BITS-1:0];
            cmd_r  <= cbe_in;
            hit_r  <= cfg_hit_w || tgt_hit_w;
            cfg_r  <= cfg_hit_w;
            rd_r   <= !cbe_in[0];
            loc_r  <= ad_in[`PCTR_WIN_HALF_BIT];
         end else if (done_w) begin
            addr_r <= addr_r + `PCTR_DW_STEP;
         end
      end
   end

   // Read data capture; local reads wait for the local side to answer.
   // local data may arrive late.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         data_ok_r <= 1'b0;
         rdat_r    <= 32'h00000000;
         phase_r   <= 2'h0;
      end else begin
         if (state_r == pctr_pkg::ST_IDLE) begin
            data_ok_r <= 1'b0;
            phase_r   <= 2'h0;
         end else if (done_w) begin
            phase_r <= phase_r + 2'h1;
         end
         if (state_r == pctr_pkg::ST_CLAIM && rd_r && (cfg_r || !loc_r)) begin
            data_ok_r <= 1'b1;
            rdat_r    <= cfg_r ? cfg_word_w : dma_rd_data;
         end else if (loc_rd_valid && rd_r && loc_r && !cfg_r && in_claim_w) begin
            data_ok_r <= 1'b1;
            rdat_r    <= loc_rd_data;
         end
      end
   end

   // The buffer keeps a stalled local side from dropping a bus word.
   pctr_buf pctr_buf_inst (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .in_side   (wr_if.snk),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_addr  (wr_addr),
      .out_data  (wr_data),
      .out_be    (wr_be)
   );

   // Checks on the sequence, all in the core_clk domain.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_cfg_addr;
      addr_ph_w && cfg_hit_w;
   endsequence
   sequence s_rd_addr;
      addr_ph_w && (cfg_hit_w || tgt_hit_w) && !cbe_in[0];
   endsequence

   AST_CFG_CLAIM: assert property (s_cfg_addr |->
      ##2 (!devseln_out && target_ctrl_out_enable))
      else $error("Config access not claimed two cycles after address phase.");
   AST_READ_OE: assert property (s_rd_addr |-> ##1 (aden == 4'h0) ##1 (aden == 4'hF))
      else $error("Data enables did not step from 0 to F after turnaround.");
   AST_SLOW_DECODE: assert property ($fell(devseln_out) |-> trdyn_out ##1 trdyn_out)
      else $error("Target-ready came sooner than two cycles after device-select.");
   AST_CFG_TRDY: assert property (s_cfg_addr |-> ##4 !trdyn_out)
      else $error("Config target-ready not at two cycles after device-select.");
   AST_READ_DATA: assert property ((done_w && rd_r) |->
      (aden == 4'hF && ad_out == rdat_r && data_ok_r))
      else $error("Read completed without valid data driven.");
   AST_CFG_STOP: assert property ((!trdyn_out && cfg_r) |-> !stopn_out)
      else $error("Config data phase without stop.");
   AST_TURN_OFF: assert property (last_w |=>
      (target_ctrl_out_enable && devseln_out && trdyn_out && stopn_out)
      ##1 !target_ctrl_out_enable)
      else $error("Controls not driven high for one cycle before release.");
   AST_WR_NO_ADEN: assert property ((state_r != pctr_pkg::ST_IDLE && !rd_r) |->
      aden == 4'h0)
      else $error("Data enables driven during a write.");
   AST_CAPTURE: assert property (addr_ph_w |=>
      (addr_r == $past(ad_in[19:0]) && cmd_r == $past(cbe_in)))
      else $error("Address or command not captured on first frame edge.");
   AST_BURST_STOP: assert property ((done_w && !rd_r && !cfg_r && phase_r == 2'h3) |->
      !stopn_out)
      else $error("Fourth write dword without disconnect.");
   AST_WR_WAIT: assert property ((in_data_w && !rd_r && !cfg_r && !wr_if.ready) |->
      trdyn_out)
      else $error("Target-ready given while the buffer is full.");
   AST_NOT_OURS: assert property ((state_r == pctr_pkg::ST_DECODE && !hit_r) |=>
      (!target_ctrl_out_enable && aden == 4'h0) [*2])
      else $error("Undecoded access drove the bus.");
endmodule : pctr_top

// *** testbench/pctr_master_model.sv ***
// Purpose: Bus master that runs single and burst transfers against the responder.
// Assumes: Lines change at the falling edge, where responder outputs are settled.
// Notes:   Idle data lanes flip every cycle, so stale data never passes for a match.
`timescale 1ns/1ps
module pctr_master_model (
   input  wire logic        core_clk,
   output      logic        framen_in,
   output      logic        irdyn_in,
   output      logic        idsel_in,
   output      logic [31:0] ad_in,
   output      logic [3:0]  cbe_in,
   input  wire logic [31:0] ad_out,
   input  wire logic [3:0]  aden,
   input  wire logic        devseln_out,
   input  wire logic        trdyn_out,
   input  wire logic        stopn_out,
   input  wire logic        target_ctrl_out_enable
);
   logic        drv = 1'b0;
   logic [31:0] m_ad = 32'h0;
   logic [31:0] last_ad = 32'h0;
   logic [31:0] rd_word;
   logic [4:0]  aden_dev;
   logic [3:0]  post1;
   logic        post2, stop_seen, timed_out, aden_any;
   int          n, dev_at, trdy_at, wait_max;

   // Each lane shows whoever drives it; the turnaround keeps the target's lanes apart.
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         ad_in[l*8 +: 8] = drv ? m_ad[l*8 +: 8] : aden[l] ? ad_out[l*8 +: 8] : ~last_ad[l*8 +: 8];
      end
   end

   // Remember the wire so that a released lane shows its inverse next cycle.
   always @(negedge core_clk) last_ad <= ad_in;

   initial begin
      framen_in = 1'b1;
      irdyn_in = 1'b1;
      idsel_in = 1'b0;
      cbe_in = 4'h0;
   end

   // One cycle, noting when the target first claims and first becomes ready.
   task automatic step();
      @(negedge core_clk);
      n++;
      if (devseln_out === 1'b0 && dev_at < 0) begin
         dev_at = n;
         aden_dev = {target_ctrl_out_enable, aden};
      end
      if (trdyn_out === 1'b0 && trdy_at < 0) trdy_at = n;
      if (aden !== 4'h0) aden_any = 1'b1;
   endtask : step

   task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
                       input logic rd, input int cnt, input logic [31:0] wd [4]);
      int k;
      n = 0;
      dev_at = -1;
      trdy_at = -1;
      wait_max = 0;
      aden_any = 1'b0;
      timed_out = 1'b0;
      @(negedge core_clk);
      framen_in = 1'b0;
      cbe_in = cmd;
      idsel_in = sel;
      m_ad = addr;
      drv = 1'b1;
      for (int i = 0; i < cnt; i++) begin
         step();
         framen_in = (i == cnt - 1);
         irdyn_in = 1'b0;
         cbe_in = 4'(i);
         drv = !rd;
         m_ad = wd[i];
         k = 0;
         while (trdyn_out !== 1'b0 && k < 12) begin
            step();
            k++;
         end
         if (i > 0 && k > wait_max) wait_max = k;
         if (k == 12) timed_out = 1'b1;
         rd_word = ad_in;
         stop_seen = !stopn_out;
      end
      step();
      post1 = {target_ctrl_out_enable, devseln_out, trdyn_out, stopn_out};
      irdyn_in = 1'b1;
      framen_in = 1'b1;
      drv = 1'b0;
      idsel_in = 1'b0;
      cbe_in = ~cbe_in;
      step();
      post2 = target_ctrl_out_enable;
   endtask : xfer
endmodule : pctr_master_model

// *** testbench/pctr_top_tb.sv ***
// Purpose: Self-checking bench for the target responder.
// Assumes: Inputs change at the falling edge; reset is held for 20 cycles.
// Notes:   The local side answers reads of the local half three cycles after the request.
`timescale 1ns/1ps
`include "pctr_map.svh"
module pctr_top_tb;
   logic        core_clk = 1'b0;
   logic        nrst, loc_rd_valid, wr_ready, rd_local_s, quiet;
   logic [11:0] win_base;
   logic [31:0] cfg_rd_data, dma_rd_data, loc_rd_data, ad_in, ad_out;
   logic [31:0] wd [4];
   logic [19:0] rd_addr, wr_addr, rd_addr_s;
   logic [3:0]  cbe_in, aden, wr_be;
   logic [7:0]  bus_latency_need, cfg_addr, cfg_addr_s;
   logic        framen_in, irdyn_in, idsel_in, devseln_out, trdyn_out, stopn_out;
   logic        target_ctrl_out_enable, rd_req, rd_local, wr_valid;
   logic [31:0] wr_data;
   logic [55:0] wq [$];
   int          fails = 0, check_count = 0, noisy = 0, loc_cnt = 0;

   always #12.5 core_clk = ~core_clk;

   pctr_top pctr_top_inst (.core_clk, .nrst, .framen_in, .irdyn_in, .idsel_in, .ad_in,
      .cbe_in, .win_base, .ad_out, .aden, .devseln_out, .trdyn_out, .stopn_out,
      .target_ctrl_out_enable, .bus_latency_need, .cfg_addr, .cfg_rd_data, .rd_req,
      .rd_local, .rd_addr, .dma_rd_data, .loc_rd_valid, .loc_rd_data, .wr_valid,
      .wr_ready, .wr_addr, .wr_data, .wr_be);

   pctr_master_model pctr_master_model_inst (.core_clk, .framen_in, .irdyn_in, .idsel_in,
      .ad_in, .cbe_in, .ad_out, .aden, .devseln_out, .trdyn_out, .stopn_out,
      .target_ctrl_out_enable);

   // Local side reply, request capture and a watch on pins that must stay released.
   always @(negedge core_clk) begin
      loc_rd_valid = (loc_cnt == 1);
      if (loc_cnt > 0) loc_cnt--;
      if (rd_req === 1'b1 && rd_local === 1'b1) loc_cnt = 3;
      if (rd_req === 1'b1) {rd_local_s, rd_addr_s} = {rd_local, rd_addr};
      if (quiet && ({target_ctrl_out_enable, aden} !== 5'h0 || devseln_out !== 1'b1)) noisy++;
      // The offset is taken in the data phase, before the completing edge steps it.
      if (trdyn_out === 1'b0) cfg_addr_s = cfg_addr;
   end

   // Words leave the buffer on an edge where valid and ready are both high.
   always @(posedge core_clk) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back({wr_be, wr_addr, wr_data});
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk

   task automatic stop_test();
      if (fails == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   // Transfers that must not be claimed, with the pins watched throughout.
   task automatic unclaimed(input logic [3:0] cmd, input logic [31:0] addr, input logic sel);
      quiet = 1'b1;
      pctr_master_model_inst.xfer(cmd, addr, sel, 1'b1, 1, wd);
      quiet = 1'b0;
      chk({pctr_master_model_inst.timed_out, 32'(noisy)}, {1'b1, 32'd0});
   endtask : unclaimed

   initial begin
      nrst = 1'b0;
      quiet = 1'b0;
      wr_ready = 1'b1;
      loc_rd_valid = 1'b0;
      win_base = 12'h123;
      cfg_rd_data = 32'hA5C3_1E77;
      dma_rd_data = 32'h1357_9BDF;
      loc_rd_data = 32'h5A3C_0F96;
      wd = '{32'hDEAD_0001, 32'h0BAD_F002, 32'hC0DE_0003, 32'hFACE_0004};
      repeat (20) @(negedge core_clk);
      chk({bus_latency_need, target_ctrl_out_enable, aden, devseln_out}, 14'h0001);
      nrst = 1'b1;
      pctr_master_model_inst.xfer(`PCTR_CMD_CFG_RD, 32'h3C, 1'b1, 1'b1, 1, wd);
      chk(pctr_master_model_inst.rd_word, {`PCTR_LAT_NEED_RST, cfg_rd_data[23:0]});
      chk(cfg_addr_s, 8'h3C);
      chk(32'(pctr_master_model_inst.dev_at), 32'd2);
      chk(pctr_master_model_inst.aden_dev, 5'h1F);
      chk(32'(pctr_master_model_inst.trdy_at), 32'd4);
      chk(pctr_master_model_inst.stop_seen, 1'b1);
      chk({pctr_master_model_inst.post1, pctr_master_model_inst.post2}, 5'h1E);
      pctr_master_model_inst.xfer(`PCTR_CMD_CFG_WR, 32'h04, 1'b1, 1'b0, 1, wd);
      chk({pctr_master_model_inst.aden_any, pctr_master_model_inst.stop_seen}, 2'b01);
      chk(cfg_addr_s, 8'h04);
      chk(32'(pctr_master_model_inst.trdy_at), 32'd4);
      unclaimed(`PCTR_CMD_CFG_RD, 32'h3C, 1'b0);
      unclaimed(`PCTR_CMD_MEM_RD, {12'h124, 20'h0000C}, 1'b0);
      pctr_master_model_inst.xfer(`PCTR_CMD_MEM_RD, {win_base, 20'h0000C},
         1'b0, 1'b1, 1, wd);
      chk(pctr_master_model_inst.rd_word, dma_rd_data);
      chk({rd_local_s, rd_addr_s}, {1'b0, 20'h0000C});
      chk(32'(pctr_master_model_inst.trdy_at), 32'd4);
      pctr_master_model_inst.xfer(`PCTR_CMD_IO_RD, {win_base, 20'h80010},
         1'b0, 1'b1, 1, wd);
      chk(pctr_master_model_inst.rd_word, loc_rd_data);
      chk({rd_local_s, rd_addr_s}, {1'b1, 20'h80010});
      chk(pctr_master_model_inst.trdy_at > 4, 1'b1);
      wr_ready = 1'b0;
      fork
         pctr_master_model_inst.xfer(`PCTR_CMD_IO_WR, {win_base, 20'h80000},
            1'b0, 1'b0, 4, wd);
         begin
            repeat (10) @(negedge core_clk);
            wr_ready = 1'b1;
         end
      join
      for (int i = 0; i < 20 && wq.size() < 4; i++) @(negedge core_clk);
      chk(32'(wq.size()), 32'd4);
      for (int i = 0; i < 4; i++) chk(wq[i], {4'(i), 20'h80000 + 20'(4 * i), wd[i]});
      chk(pctr_master_model_inst.wait_max > 0, 1'b1);
      chk({pctr_master_model_inst.stop_seen, pctr_master_model_inst.timed_out}, 2'b10);
      // A single memory write into the register half, with the local side ready.
      pctr_master_model_inst.xfer(`PCTR_CMD_MEM_WR, {win_base, 20'h00020},
         1'b0, 1'b0, 1, wd);
      for (int i = 0; i < 20 && wq.size() < 5; i++) @(negedge core_clk);
      chk(32'(wq.size()), 32'd5);
      chk(wq[4], {4'h0, 20'h00020, wd[0]});
      chk(pctr_master_model_inst.stop_seen, 1'b0);
      chk(32'(pctr_master_model_inst.trdy_at), 32'd4);
      stop_test();
   end
endmodule : pctr_top_tb
